// [dv/lsvc_ee_model.sv]
// serial eeprom seen through the product-data engine port, answers DELAY plus one clocks after req
// assumes req stays high until the cycle after done, all on clk_sys
`timescale 1ns/1ps

module lsvc_ee_model #(
  parameter int DELAY = 8
) (
  input wire logic clk_sys,
  input wire lsvc_pkg::lsvc_ee_req_s ee_req,
  output lsvc_pkg::lsvc_ee_rsp_s ee_rsp
);
  logic [31:0] mem [logic [8:0]];
  int cnt;

  initial begin
    ee_rsp = '0;
    cnt = 0;
  end

  // one done pulse per cycle; data toggles outside done so stale words never pass
  always @(posedge clk_sys) begin
    ee_rsp.done <= 1'b0;
    ee_rsp.rdata <= ~ee_rsp.rdata;
    if (!ee_req.req) begin
      cnt <= 0;
    end else if (cnt < DELAY) begin
      cnt <= cnt + 1;
    end else if (cnt == DELAY) begin
      cnt <= cnt + 1;
      ee_rsp.done <= 1'b1;
      if (ee_req.write) begin
        mem[ee_req.addr] = ee_req.wdata;
      end else if (mem.exists(ee_req.addr)) begin
        ee_rsp.rdata <= mem[ee_req.addr];
      end else begin
        ee_rsp.rdata <= {16'hc0de, 7'h00, ee_req.addr};
      end
    end
  end
endmodule // lsvc_ee_model

// [dv/lsvc_regs_test.sv]
// self-checking bench for the config bank: register table, debounce, product-data cycles
// assumes the bank's one-cycle config port and the eeprom model beside it
`timescale 1ns/1ps

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end

module lsvc_regs_test;
  logic clk_sys;
  logic reset;
  lsvc_pkg::lsvc_cfg_req_s cfg_req;
  lsvc_pkg::lsvc_cfg_rsp_s cfg_rsp;
  lsvc_pkg::lsvc_ee_req_s ee_req;
  lsvc_pkg::lsvc_ee_rsp_s ee_rsp;
  logic [6:0] slot_status_in;
  logic hot_swap_en;
  logic swap_switch_in;
  logic swap_switch_db;
  lsvc_pkg::lsvc_link_s link;
  logic [31:0] rd;
  int fail_count = 0;
  int checked = 0;

  // short millisecond so the debounce fits in a few dozen cycles
  lsvc_regs #(.MS_CYCLES(10)) dut_u (.clk_sys(clk_sys), .reset(reset), .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp), .ee_req(ee_req), .ee_rsp(ee_rsp), .slot_status_in(slot_status_in),
    .hot_swap_en(hot_swap_en), .swap_switch_in(swap_switch_in),
    .swap_switch_db(swap_switch_db), .link(link));

  lsvc_ee_model #(.DELAY(8)) ee_u (.clk_sys(clk_sys), .ee_req(ee_req), .ee_rsp(ee_rsp));

  always #10 clk_sys = ~clk_sys;

  // --------------------------------------------------------------
  // access tasks
  // --------------------------------------------------------------
  // one access: strobe for a cycle, answer looked at the cycle after it is taken
  task automatic cfg(input logic we, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    @(posedge clk_sys);
    cfg_req <= '{req: 1'b1, we: we, addr: a, be: be, wdata: d};
    @(posedge clk_sys);
    cfg_req.req <= 1'b0;
    // look at the answer mid-cycle, away from the edges that move it
    @(negedge clk_sys);
    `CHK(cfg_rsp.ack, 1'b1)
    rd = cfg_rsp.rdata;
    @(posedge clk_sys);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    cfg(1'b0, a, 4'h0, 32'h0);
    `CHK(rd, exp)
  endtask

  // poll the operation flag, bounded so a stuck cycle cannot hang the run
  task automatic wait_flag(input logic f);
    for (int i = 0; i < 40; i++) begin
      cfg(1'b0, 8'hd8, 4'h0, 32'h0);
      if (rd[31] === f) begin
        break;
      end
    end
  endtask

  task automatic stop_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    cfg_req = '0;
    slot_status_in = '0;
    hot_swap_en = 1'b0;
    swap_switch_in = 1'b0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    // reset image of every word but the data word, and a hole that reads zero
    rdchk(8'hc8, 32'h0);
    rdchk(8'hcc, 32'h0400_1060);
    rdchk(8'hd0, 32'h0400_0217);
    rdchk(8'hd4, 32'h0019_0254);
    rdchk(8'hd8, 32'h0000_f003);
    rdchk(8'he0, 32'h0);
    `CHK(link.fts_symbols, 10'h150)
    `CHK({link.hot_reset, link.loopback, link.sw_to_config}, 3'h0)
    `CHK({link.cross_link, link.debug_sel, link.l1_entry}, {2'h0, 16'h0400})
    `CHK({link.l0s_exit, link.l1_exit}, {7'h2, 7'h19})
    // all ones everywhere but the data word: only writable bits stick, debounce byte locked
    cfg(1'b1, 8'hcc, 4'hf, '1);
    rdchk(8'hcc, 32'hffff_1fff);
    cfg(1'b1, 8'hd0, 4'hf, '1);
    rdchk(8'hd0, 32'hffff_03ff);
    cfg(1'b1, 8'hd4, 4'hf, '1);
    rdchk(8'hd4, 32'h007f_7fff);
    cfg(1'b1, 8'hd8, 4'h3, '1);
    rdchk(8'hd8, 32'h0000_f003);
    cfg(1'b1, 8'hc8, 4'hf, '1);
    rdchk(8'hc8, 32'h0);
    `CHK({link.lane_tries, link.ts1_count, link.l1_entry}, {3'h7, 5'h1f, 16'hffff})
    `CHK({link.l0s_life, link.l1_life}, {10'h3ff, 16'hffff})
    `CHK({link.l0s_exit, link.l1_exit, link.cdr_fts}, {7'h7f, 7'h7f, 8'hff})
    `CHK(link.fts_symbols, 10'h3fc)
    // unlock, set 3 ms, switch must hold off until 30 cycles plus sync
    hot_swap_en <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cfg(1'b1, 8'hd4, 4'h8, 32'h0200_0000);
    rdchk(8'hd4, 32'h027f_7fff);
    // 2 sync edges, then 3 ms of 10 cycles: flips at the 32nd edge
    swap_switch_in <= 1'b1;
    repeat (30) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(swap_switch_db, 1'b0)
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(swap_switch_db, 1'b1)
    @(posedge clk_sys);
    hot_swap_en <= 1'b0;
    repeat (4) @(posedge clk_sys);
    cfg(1'b1, 8'hd4, 4'h8, '1);
    rdchk(8'hd4, 32'h027f_7fff);
    slot_status_in <= 7'h55;
    repeat (4) @(posedge clk_sys);
    rdchk(8'hc8, 32'h0055_0000);
    // read at word 5; a control write in mid-cycle must be dropped
    cfg(1'b1, 8'hd8, 4'hc, {8'h00, 6'h05, 18'h0});
    rdchk(8'hd8, {8'h00, 6'h05, 18'h0f003});
    cfg(1'b1, 8'hd8, 4'hc, {8'h80, 6'h3f, 18'h0});
    wait_flag(1'b1);
    `CHK(rd, {8'h80, 6'h05, 18'h0f003})
    rdchk(8'hec, 32'hc0de_0054);
    rdchk(8'hdc, 32'hc0de_0054);
    // write word 7, then read it back through a fresh read cycle
    cfg(1'b1, 8'hec, 4'hf, 32'h1234_abcd);
    cfg(1'b1, 8'hd8, 4'hc, {8'h80, 6'h07, 18'h0});
    rdchk(8'hd8, {8'h80, 6'h07, 18'h0f003});
    `CHK(ee_req.addr, 9'h05c)
    wait_flag(1'b0);
    `CHK(rd[31], 1'b0)
    // clear the data word first, so the read-back can only come from the eeprom
    cfg(1'b1, 8'hdc, 4'hf, 32'h0);
    cfg(1'b1, 8'hd8, 4'hc, {8'h00, 6'h07, 18'h0});
    wait_flag(1'b1);
    `CHK(rd[31], 1'b1)
    rdchk(8'hec, 32'h1234_abcd);
    // mid-run reset while idle: written words and the debounce byte go back to reset
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    `CHK(swap_switch_db, 1'b0)
    rdchk(8'hcc, 32'h0400_1060);
    rdchk(8'hd4, 32'h0019_0254);
    rdchk(8'hd8, 32'h0000_f003);
    stop_test();
  end
endmodule // lsvc_regs_test

// [hdl/lsvc_pkg.sv]
// constants, carriers and state layout of the link, slot and product-data config bank
// assumes one 50 MHz clock and a same-clock config port and eeprom engine
package lsvc_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses of dwords)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_SLOT = 8'hc8;
  localparam logic [7:0] OFS_LINK0 = 8'hcc;
  localparam logic [7:0] OFS_LINK1 = 8'hd0;
  localparam logic [7:0] OFS_LINK2 = 8'hd4;
  localparam logic [7:0] OFS_VPD = 8'hd8;
  localparam logic [7:0] OFS_VPD_DATA = 8'hec;
  localparam logic [7:0] OFS_VPD_DATA_ALT = 8'hdc;

  // ---------------------------------------------------------------
  // reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [31:0] LINK0_RST = 32'h0400_1060;
  localparam logic [31:0] LINK0_WMASK = 32'hffff_1fff;
  localparam logic [31:0] LINK1_RST = 32'h0400_0217;
  localparam logic [31:0] LINK1_WMASK = 32'hffff_03ff;
  localparam logic [31:0] LINK2_RST = 32'h0019_0254;
  localparam logic [31:0] LINK2_WMASK = 32'h007f_7fff;
  localparam logic [31:0] DEB_WMASK = 32'hff00_0000;
  localparam logic [7:0] VPD_CAP_ID = 8'h03;
  localparam logic [7:0] VPD_NEXT_PTR = 8'hf0;
  localparam logic [8:0] EE_BASE = 9'h040;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int HOT_RESET_POS = 0;
  localparam int LOOPBACK_POS = 1;
  localparam int CROSS_LINK_POS = 2;
  localparam int SW_CFG_POS = 3;
  localparam int DEBUG_POS = 4;
  localparam int LANE_TRIES_POS = 5;
  localparam int TS1_POS = 8;
  localparam int L1_ENTRY_POS = 16;
  localparam int L0S_LIFE_POS = 0;
  localparam int L1_LIFE_POS = 16;
  localparam int CDR_POS = 0;
  localparam int L0S_EXIT_POS = 8;
  localparam int L1_EXIT_POS = 16;
  localparam int DEBOUNCE_POS = 24;
  localparam int SLOT_POS = 16;
  localparam int VPD_ADDR_POS = 18;
  localparam int VPD_FLAG_POS = 31;

  // ---------------------------------------------------------------
  // fast training sequence make-up and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] FTS_COMMA = 8'hbc;
  localparam logic [7:0] FTS_FILL = 8'h3c;
  localparam int FTS_FILL_COUNT = 3;
  localparam int CLK_MHZ = 50;
  localparam int MS_TIME_US = 1000;
  localparam int MS_CYCLES = MS_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    LSVC_IDLE = 2'b00,
    LSVC_RUN = 2'b01
  } lsvc_vpd_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } lsvc_cfg_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } lsvc_cfg_rsp_s;

  typedef struct packed {
    logic req;
    logic write;
    logic [8:0] addr;
    logic [31:0] wdata;
  } lsvc_ee_req_s;

  typedef struct packed {
    logic done;
    logic [31:0] rdata;
  } lsvc_ee_rsp_s;

  typedef struct packed {
    logic hot_reset;
    logic loopback;
    logic cross_link;
    logic sw_to_config;
    logic debug_sel;
    logic [2:0] lane_tries;
    logic [4:0] ts1_count;
    logic [15:0] l1_entry;
    logic [9:0] l0s_life;
    logic [15:0] l1_life;
    logic [7:0] cdr_fts;
    logic [9:0] fts_symbols;
    logic [6:0] l0s_exit;
    logic [6:0] l1_exit;
  } lsvc_link_s;

  typedef struct packed {
    logic [6:0] slot_s1;
    logic [6:0] slot_s2;
    logic sw_s1;
    logic sw_s2;
    logic sw_stable;
    logic hs_s1;
    logic hs_s2;
    logic [31:0] link0;
    logic [31:0] link1;
    logic [31:0] link2;
    logic [5:0] vpd_addr;
    logic vpd_flag;
    lsvc_vpd_e vstate;
    logic [31:0] vpd_data;
    logic [15:0] ms_cnt;
    logic [7:0] ms_done;
    logic ack;
    logic [31:0] rdata;
  } lsvc_state_s;

  // byte-enabled merge of a write into the writable bits of a word
  function automatic logic [31:0] lsvc_merge(input logic [31:0] old_w, input logic [31:0] wr_w,
                                             input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] bm;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    return (old_w & ~bm) | (wr_w & bm);
  endfunction

endpackage

// [hdl/lsvc_regs.sv]
// config register bank: slot status, link phy settings, swap debounce, product-data port
// assumes config requests, and the eeprom engine, run on clk_sys; slot and switch pins do not
//
// Contract
// - cross-link enable bit 2 and debug select bit 4, read-write, reset zero.
// - lane negotiation tries bits 7:5 reset 3h; TS1 count bits 12:8 reset 10h.
// - L1 entry timer default, bits 31:16 read-write, reset 0400h.
// - clock-recovery time, 8-bit FTS count in bits 7:0, reset 54h.
// - each FTS set is one K28.5 then three K28.1 symbols.
// - L0s exit latency, 7 bits at 14:8, reset 2h.
// - L1 exit latency, 7 bits at 22:16, reset 19h.
// - debounce time is field plus one milliseconds, field at 31:24, reset zero.
// - debounce field writable only while hot swap is enabled.
// - capability id 03h read-only in bits 7:0.
// - next pointer F0h read-only in bits 15:8.
// - writing operation flag 0 starts eeprom read at address field 23:18.
// - read keeps flag 0 until done, then sets it to 1.
// - read data lands in the product-data data register.
// - write keeps flag 1 while running, clears it when done.
// - eeprom byte address is programmed address plus 40h; the bank sends four times field 23:18 plus 40h.
`timescale 1ns/1ps

module lsvc_regs #(
  parameter int MS_CYCLES = lsvc_pkg::MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire lsvc_pkg::lsvc_cfg_req_s cfg_req,
  output lsvc_pkg::lsvc_cfg_rsp_s cfg_rsp,
  output lsvc_pkg::lsvc_ee_req_s ee_req,
  input wire lsvc_pkg::lsvc_ee_rsp_s ee_rsp,
  input wire logic [6:0] slot_status_in,
  input wire logic hot_swap_en,
  input wire logic swap_switch_in,
  output logic swap_switch_db,
  output lsvc_pkg::lsvc_link_s link
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  lsvc_pkg::lsvc_state_s st;
  lsvc_pkg::lsvc_state_s next_st;
  logic [15:0] ms_last;
  logic [31:0] deb_mask;

  assign ms_last = 16'(MS_CYCLES - 1);
  // the debounce byte drops out of the mask while hot swap is off
  // debounce write gate
  assign deb_mask = st.hs_s2 ? (lsvc_pkg::LINK2_WMASK | lsvc_pkg::DEB_WMASK) :
                    lsvc_pkg::LINK2_WMASK;

  // next-state logic
  always_comb begin
    next_st = st;
    // pins pass two flops before any logic looks at them
    next_st.slot_s1 = slot_status_in;
    next_st.slot_s2 = st.slot_s1;
    next_st.sw_s1 = swap_switch_in;
    next_st.sw_s2 = st.sw_s1;
    next_st.hs_s1 = hot_swap_en;
    next_st.hs_s2 = st.hs_s1;
    next_st.ack = cfg_req.req;
    // writes
    if (cfg_req.req && cfg_req.we) begin
      case (cfg_req.addr)
        lsvc_pkg::OFS_LINK0: begin
          next_st.link0 = lsvc_pkg::lsvc_merge(st.link0, cfg_req.wdata, cfg_req.be,
                                               lsvc_pkg::LINK0_WMASK);
        end
        lsvc_pkg::OFS_LINK1: begin
          next_st.link1 = lsvc_pkg::lsvc_merge(st.link1, cfg_req.wdata, cfg_req.be,
                                               lsvc_pkg::LINK1_WMASK);
        end
        lsvc_pkg::OFS_LINK2: begin
          next_st.link2 = lsvc_pkg::lsvc_merge(st.link2, cfg_req.wdata, cfg_req.be, deb_mask);
        end
        lsvc_pkg::OFS_VPD: begin
          // control changes are ignored while a cycle runs, so the address cannot move under it
          if (st.vstate == lsvc_pkg::LSVC_IDLE) begin
            if (cfg_req.be[2]) begin
              next_st.vpd_addr = cfg_req.wdata[lsvc_pkg::VPD_ADDR_POS +: 6];
            end
            if (cfg_req.be[3]) begin
              next_st.vpd_flag = cfg_req.wdata[lsvc_pkg::VPD_FLAG_POS];
              next_st.vstate = lsvc_pkg::LSVC_RUN;
            end
          end
        end
        lsvc_pkg::OFS_VPD_DATA, lsvc_pkg::OFS_VPD_DATA_ALT: begin
          next_st.vpd_data = lsvc_pkg::lsvc_merge(st.vpd_data, cfg_req.wdata, cfg_req.be,
                                                  32'hffff_ffff);
        end
        default: begin
        end
      endcase
    end
    // reads, answered one cycle later
    if (cfg_req.req && !cfg_req.we) begin
      case (cfg_req.addr)
        lsvc_pkg::OFS_SLOT: next_st.rdata = {9'h000, st.slot_s2, 16'h0000};
        lsvc_pkg::OFS_LINK0: next_st.rdata = st.link0;
        lsvc_pkg::OFS_LINK1: next_st.rdata = st.link1;
        lsvc_pkg::OFS_LINK2: next_st.rdata = st.link2;
        lsvc_pkg::OFS_VPD: begin
          next_st.rdata = {st.vpd_flag, 7'h00, st.vpd_addr, 2'b00, lsvc_pkg::VPD_NEXT_PTR,
                           lsvc_pkg::VPD_CAP_ID};
        end
        lsvc_pkg::OFS_VPD_DATA, lsvc_pkg::OFS_VPD_DATA_ALT: next_st.rdata = st.vpd_data;
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    // eeprom completion; wins over a data write in the same cycle
    case (st.vstate)
      lsvc_pkg::LSVC_IDLE: begin
      end
      lsvc_pkg::LSVC_RUN: begin
        if (ee_rsp.done) begin
          next_st.vstate = lsvc_pkg::LSVC_IDLE;
          next_st.vpd_flag = ~st.vpd_flag;
          if (!st.vpd_flag) begin
            next_st.vpd_data = ee_rsp.rdata;
          end
        end
      end
      default: next_st.vstate = lsvc_pkg::LSVC_IDLE;
    endcase
    // switch must differ for field plus one whole milliseconds
    if (st.sw_s2 == st.sw_stable) begin
      next_st.ms_cnt = 16'h0000;
      next_st.ms_done = 8'h00;
    end else if (st.ms_cnt == ms_last) begin
      next_st.ms_cnt = 16'h0000;
      if (st.ms_done == st.link2[lsvc_pkg::DEBOUNCE_POS +: 8]) begin
        next_st.sw_stable = st.sw_s2;
        next_st.ms_done = 8'h00;
      end else begin
        next_st.ms_done = st.ms_done + 8'h01;
      end
    end else begin
      next_st.ms_cnt = st.ms_cnt + 16'h0001;
    end
  end

  // state register
  // reset values
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.link0 <= lsvc_pkg::LINK0_RST;
      st.link1 <= lsvc_pkg::LINK1_RST;
      st.link2 <= lsvc_pkg::LINK2_RST;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign cfg_rsp.ack = st.ack;
  assign cfg_rsp.rdata = st.rdata;
  assign ee_req.req = (st.vstate == lsvc_pkg::LSVC_RUN);
  assign ee_req.write = st.vpd_flag;
  assign ee_req.addr = lsvc_pkg::EE_BASE + {1'b0, st.vpd_addr, 2'b00};
  assign ee_req.wdata = st.vpd_data;
  assign swap_switch_db = st.sw_stable;

  // link settings straight from the words, except the FTS symbol total, which is derived
  assign link.hot_reset = st.link0[lsvc_pkg::HOT_RESET_POS];
  assign link.loopback = st.link0[lsvc_pkg::LOOPBACK_POS];
  assign link.cross_link = st.link0[lsvc_pkg::CROSS_LINK_POS];
  assign link.sw_to_config = st.link0[lsvc_pkg::SW_CFG_POS];
  assign link.debug_sel = st.link0[lsvc_pkg::DEBUG_POS];
  assign link.lane_tries = st.link0[lsvc_pkg::LANE_TRIES_POS +: 3];
  assign link.ts1_count = st.link0[lsvc_pkg::TS1_POS +: 5];
  assign link.l1_entry = st.link0[lsvc_pkg::L1_ENTRY_POS +: 16];
  assign link.l0s_life = st.link1[lsvc_pkg::L0S_LIFE_POS +: 10];
  assign link.l1_life = st.link1[lsvc_pkg::L1_LIFE_POS +: 16];
  assign link.cdr_fts = st.link2[lsvc_pkg::CDR_POS +: 8];
  // one comma plus three fill symbols per set
  assign link.fts_symbols = {2'b00, st.link2[lsvc_pkg::CDR_POS +: 8]} * 10'(1 + lsvc_pkg::FTS_FILL_COUNT);
  assign link.l0s_exit = st.link2[lsvc_pkg::L0S_EXIT_POS +: 7];
  assign link.l1_exit = st.link2[lsvc_pkg::L1_EXIT_POS +: 7];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence start_seq(logic f);
    cfg_req.req && cfg_req.we && cfg_req.addr == lsvc_pkg::OFS_VPD && cfg_req.be[3] &&
      st.vstate == lsvc_pkg::LSVC_IDLE && cfg_req.wdata[31] == f;
  endsequence

  sequence finish_seq(logic f);
    st.vstate == lsvc_pkg::LSVC_RUN && st.vpd_flag == f && ee_rsp.done;
  endsequence

  cap_word_a: assert property (
    cfg_req.req && !cfg_req.we && cfg_req.addr == lsvc_pkg::OFS_VPD
    |=> cfg_rsp.ack && cfg_rsp.rdata[15:0] == 16'hf003) else $error("bad capability header");
  vpd_start_a: assert property (
    start_seq(1'b0) |=> ee_req.req && !ee_req.write) else $error("read not started");
  vpd_hold_a: assert property (
    st.vstate == lsvc_pkg::LSVC_RUN && !ee_rsp.done |=> $stable(st.vpd_flag) && ee_req.req)
    else $error("flag moved mid cycle");
  read_done_a: assert property (
    finish_seq(1'b0) |=> st.vpd_flag && !ee_req.req && st.vpd_data == $past(ee_rsp.rdata))
    else $error("read completion wrong");
  write_done_a: assert property (
    start_seq(1'b1) ##[1:1000] finish_seq(1'b1) |=> !st.vpd_flag && !ee_req.req)
    else $error("write completion wrong");
  ee_addr_a: assert property (
    start_seq(1'b0) && cfg_req.be[2]
    |=> ee_req.req && ee_req.addr == {1'b0, $past(cfg_req.wdata[23:18]), 2'b00} + 9'h040)
    else $error("eeprom address wrong");
  debounce_lock_a: assert property (
    cfg_req.req && cfg_req.we && cfg_req.addr == lsvc_pkg::OFS_LINK2 && !st.hs_s2
    |=> $stable(st.link2[31:24])) else $error("debounce written while locked");
  link0_write_a: assert property (
    cfg_req.req && cfg_req.we && cfg_req.addr == lsvc_pkg::OFS_LINK0 && cfg_req.be[0]
    |=> link.cross_link == $past(cfg_req.wdata[2]) && link.debug_sel == $past(cfg_req.wdata[4]))
    else $error("link word zero write lost");
  exit_read_a: assert property (
    cfg_req.req && !cfg_req.we && cfg_req.addr == lsvc_pkg::OFS_LINK2
    |=> cfg_rsp.rdata[14:8] == link.l0s_exit && cfg_rsp.rdata[22:16] == link.l1_exit)
    else $error("exit latency read wrong");
  slot_read_a: assert property (
    cfg_req.req && !cfg_req.we && cfg_req.addr == lsvc_pkg::OFS_SLOT
    |=> cfg_rsp.rdata[22:16] == $past(st.slot_s2) && cfg_rsp.rdata[31:23] == 9'h000)
    else $error("slot status read wrong");

endmodule // lsvc_regs
